// ==== hw/swd_pkg.sv ====
package swd_pkg;
  // register byte offsets
  localparam logic [7:0] SWD_OFS_CTRL    = 8'h00;
  localparam logic [7:0] SWD_OFS_START   = 8'h04;
  localparam logic [7:0] SWD_OFS_RELOAD  = 8'h08;
  localparam logic [7:0] SWD_OFS_STANDBY = 8'h0c;
  localparam logic [7:0] SWD_OFS_STATUS  = 8'h10;
  localparam logic [7:0] SWD_OFS_COUNT   = 8'h14;
  localparam logic [7:0] SWD_OFS_IRQ_ST  = 8'h18;
  localparam logic [7:0] SWD_OFS_IRQ_MSK = 8'h1c;
  // control fields
  localparam int SWD_CTRL_EN        = 0;
  localparam int SWD_CTRL_MODE_LSB  = 4;
  localparam int SWD_MODE_W         = 4;
  // action mask bits
  localparam int SWD_ACT_MAIN       = 0;
  localparam int SWD_ACT_SEC        = 1;
  localparam int SWD_ACT_WDOUT      = 2;
  localparam int SWD_ACT_GPIO       = 3;
  // status bits
  localparam int SWD_ST_EN          = 0;
  localparam int SWD_ST_FAULT       = 1;
  // counter
  localparam int SWD_CNT_W          = 16;
  localparam logic [15:0] SWD_START_MIN = 16'h0001;
  localparam logic [15:0] SWD_START_MAX = 16'hfffe;
  localparam logic [15:0] SWD_START_RST = 16'hfffe;
  // tick timing
  localparam int SWD_TICK_US        = 10;
  localparam int SWD_CLK_MHZ        = 20;
  localparam int SWD_TICK_CYC       = SWD_TICK_US * SWD_CLK_MHZ;
  localparam int SWD_DIV_W          = 8;
  // irq bits
  localparam int SWD_IRQ_TIMEOUT    = 0;
  localparam int SWD_IRQ_RELOAD     = 1;
  localparam int SWD_IRQ_W          = 2;
endpackage : swd_pkg

// ==== hw/swd_tick.sv ====
`timescale 1ns/1ns
module swd_tick
  import swd_pkg::*;
#(
  parameter int CYCLES = SWD_TICK_CYC
)(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic run,
  output logic      tick
);
  // cycle count must be at least 2 and fit the divider register
  if (CYCLES < 2 || CYCLES >= 2**SWD_DIV_W)
  begin : g_bad_cycles
    $error("swd_tick: CYCLES out of range");
  end

  logic [SWD_DIV_W-1:0] cnt;
  logic [SWD_DIV_W-1:0] next_cnt;
  logic                 next_tick;
  localparam logic [SWD_DIV_W-1:0] LAST = SWD_DIV_W'(CYCLES - 1);

  always_comb
  begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run)
      next_cnt = '0;
    else if (cnt == LAST)
    begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end
    else
      next_cnt = cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : swd_tick

// ==== hw/swd_top.sv ====
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// RL1 - counter disabled after reset; enable bit starts it
// RL2 - start value 1 to fffe, 10 us units
// RL3 - enabled counter decrements each 10 us tick
// RL4 - reaching zero is malfunction; run selected actions
// RL5 - mask: main, secondary, watchdog out, outputs
// RL6 - reload restores start value, stays enabled
// RL7 - reload ignored while disabled
// RL8 - software reloads within each counting period
// RL9 - mode bit2: output high counting, low expired
// RL10 - otherwise output follows standby level
// RL11 - watchdog output low after power-up
// RL12 - status bit0 enable, bit1 malfunction
// RL13 - bit1 meaningless while disabled
// RL14 - enabling loads start value before decrementing
// RL15 - expired: stop counting, hold actions asserted
module swd_top
  import swd_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // timeout actions
  output logic             halt_main,
  output logic             halt_secondary,
  output logic             wd_out,
  output logic             general_outputs_force_low,
  // interrupt
  output logic             irq
);
  logic                  enable;
  logic [SWD_MODE_W-1:0] mode;
  logic [SWD_CNT_W-1:0]  start_val;
  logic                  standby;
  logic [SWD_CNT_W-1:0]  count;
  logic                  fault;
  logic [SWD_IRQ_W-1:0]  irq_st;
  logic [SWD_IRQ_W-1:0]  irq_msk;
  logic                  tick;

  logic                  next_enable;
  logic [SWD_MODE_W-1:0] next_mode;
  logic [SWD_CNT_W-1:0]  next_start_val;
  logic                  next_standby;
  logic [SWD_CNT_W-1:0]  next_count;
  logic                  next_fault;
  logic [SWD_IRQ_W-1:0]  next_irq_st;
  logic [SWD_IRQ_W-1:0]  next_irq_msk;
  logic [31:0]           next_prdata;
  logic                  next_pslverr;
  logic                  next_halt_main;
  logic                  next_halt_sec;
  logic                  next_wd_out;
  logic                  next_gpo_low;
  logic                  next_irq;

  logic                  wr_acc;
  logic                  rd_acc;
  logic                  reload;
  logic                  addr_ok;
  logic [SWD_IRQ_W-1:0]  ev;

  // divider runs only while counting, so first tick is a full period
  swd_tick #(.CYCLES(SWD_TICK_CYC)) u_tick
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (enable && !fault),
    .tick    (tick)
  );

  // zero wait states: every access completes in its access phase
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign reload = wr_acc && paddr == SWD_OFS_RELOAD && pstrb[0];

  always_comb
  begin
    unique case (paddr)
      SWD_OFS_CTRL, SWD_OFS_START, SWD_OFS_RELOAD, SWD_OFS_STANDBY,
      SWD_OFS_STATUS, SWD_OFS_COUNT, SWD_OFS_IRQ_ST, SWD_OFS_IRQ_MSK:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // configuration registers
  always_comb
  begin
    next_enable    = enable;
    next_mode      = mode;
    next_start_val = start_val;
    next_standby   = standby;
    next_irq_msk   = irq_msk;
    if (wr_acc && pstrb[0])
    begin
      unique case (paddr)
        SWD_OFS_CTRL:
        begin
          next_enable = pwdata[SWD_CTRL_EN]; // RL1
          next_mode   = pwdata[SWD_CTRL_MODE_LSB +: SWD_MODE_W];
        end
        SWD_OFS_STANDBY: next_standby = pwdata[0];
        SWD_OFS_IRQ_MSK: next_irq_msk = pwdata[SWD_IRQ_W-1:0];
        default: ;
      endcase
    end
    // out-of-range start values are refused, old value kept
    if (wr_acc && paddr == SWD_OFS_START && (&pstrb[1:0])
        && pwdata[15:0] >= SWD_START_MIN
        && pwdata[15:0] <= SWD_START_MAX) // RL2
      next_start_val = pwdata[15:0];
  end

  // counter engine
  always_comb
  begin
    next_count = count;
    next_fault = fault;
    if (next_enable && !enable)
    begin
      next_count = next_start_val; // RL14
      next_fault = 1'b0;
    end
    else if (!enable)
      next_fault = 1'b0;
    else if (reload)
    begin
      next_count = start_val; // RL6 RL7
      next_fault = 1'b0;
    end
    else if (!fault && tick)
    begin
      next_count = count - 1'b1; // RL3
      if (count == SWD_CNT_W'(1))
        next_fault = 1'b1; // RL4 RL15
    end
    // disabling while expired releases all actions
    if (!next_enable)
      next_fault = 1'b0;
  end

  // sticky events: set wins over write-one-clear
  assign ev[SWD_IRQ_TIMEOUT] = next_fault && !fault;
  assign ev[SWD_IRQ_RELOAD]  = reload && enable;

  always_comb
  begin
    next_irq_st = irq_st;
    if (wr_acc && paddr == SWD_OFS_IRQ_ST && pstrb[0])
      next_irq_st = irq_st & ~pwdata[SWD_IRQ_W-1:0];
    next_irq_st = next_irq_st | ev;
    next_irq    = |(next_irq_st & next_irq_msk);
  end

  // outputs
  always_comb
  begin
    next_halt_main = next_fault && mode[SWD_ACT_MAIN]; // RL5
    next_halt_sec  = next_fault && mode[SWD_ACT_SEC]; // RL5
    next_gpo_low   = next_fault && mode[SWD_ACT_GPIO]; // RL5
    if (next_mode[SWD_ACT_WDOUT] && next_enable)
      next_wd_out = !next_fault; // RL9
    else
      next_wd_out = next_standby; // RL10
  end

  // read mux
  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_pslverr = !addr_ok;
      unique case (paddr)
        SWD_OFS_CTRL:
        begin
          next_prdata[SWD_CTRL_EN] = enable;
          next_prdata[SWD_CTRL_MODE_LSB +: SWD_MODE_W] = mode;
        end
        SWD_OFS_START:   next_prdata[15:0] = start_val;
        SWD_OFS_STANDBY: next_prdata[0] = standby;
        SWD_OFS_STATUS:
        begin
          next_prdata[SWD_ST_EN]    = enable; // RL12
          next_prdata[SWD_ST_FAULT] = fault; // RL12 RL13
        end
        SWD_OFS_COUNT:   next_prdata[15:0] = count;
        SWD_OFS_IRQ_ST:  next_prdata[SWD_IRQ_W-1:0] = irq_st;
        SWD_OFS_IRQ_MSK: next_prdata[SWD_IRQ_W-1:0] = irq_msk;
        default: ;
      endcase
    end
    else if (psel && penable)
    begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable         <= 1'b0; // RL1
      mode           <= '0;
      start_val      <= SWD_START_RST;
      standby        <= 1'b0;
      count          <= '0;
      fault          <= 1'b0;
      irq_st         <= '0;
      irq_msk        <= '0;
      prdata         <= 32'h0000_0000;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      halt_main      <= 1'b0;
      halt_secondary <= 1'b0;
      wd_out         <= 1'b0; // RL11
      general_outputs_force_low <= 1'b0;
      irq            <= 1'b0;
    end
    else
    begin
      enable         <= next_enable;
      mode           <= next_mode;
      start_val      <= next_start_val;
      standby        <= next_standby;
      count          <= next_count;
      fault          <= next_fault;
      irq_st         <= next_irq_st;
      irq_msk        <= next_irq_msk;
      prdata         <= next_prdata;
      pready         <= psel && !penable;
      pslverr        <= next_pslverr;
      halt_main      <= next_halt_main;
      halt_secondary <= next_halt_sec;
      wd_out         <= next_wd_out;
      general_outputs_force_low <= next_gpo_low;
      irq            <= next_irq;
    end
  end

  // checks
  AST_RESET_DISABLED: assert property (@(posedge pclk) // RL1
    $rose(presetn) |-> !enable && !wd_out)
    else $error("enable or wd_out set after reset");
  AST_START_RANGE: assert property (@(posedge pclk) // RL2
    disable iff (!presetn)
    start_val >= SWD_START_MIN && start_val <= SWD_START_MAX)
    else $error("start value out of range");
  AST_DECREMENT: assert property (@(posedge pclk) // RL3
    disable iff (!presetn)
    enable && !fault && tick && !reload && $stable(enable) |=>
    count == $past(count) - 16'h0001)
    else $error("counter did not decrement on tick");
  AST_TIMEOUT: assert property (@(posedge pclk) // RL4
    disable iff (!presetn)
    enable && tick && count == 16'h0001 && !reload && !wr_acc
    |=> fault ##1 (halt_main == mode[SWD_ACT_MAIN]))
    else $error("timeout not flagged");
  AST_RELOAD: assert property (@(posedge pclk) // RL6
    disable iff (!presetn)
    reload && enable && !(wr_acc && paddr == SWD_OFS_CTRL)
    |=> count == $past(start_val) && enable && !fault)
    else $error("reload did not restore start value");
  AST_RELOAD_OFF: assert property (@(posedge pclk) // RL7
    disable iff (!presetn)
    reload && !enable |=> !enable && $stable(count))
    else $error("reload acted while disabled");
  // wd_out register takes next values, so pin and state line up
  AST_WDOUT: assert property (@(posedge pclk) // RL9
    disable iff (!presetn)
    enable && mode[SWD_ACT_WDOUT] |-> wd_out == !fault)
    else $error("wd_out does not follow watchdog state");
  AST_STANDBY: assert property (@(posedge pclk) // RL10
    disable iff (!presetn)
    !(enable && mode[SWD_ACT_WDOUT]) |-> wd_out == standby)
    else $error("wd_out does not follow standby");
  // a control write may legally disable and release the fault
  AST_HOLD: assert property (@(posedge pclk) // RL15
    disable iff (!presetn)
    fault && enable && !reload && !(wr_acc && paddr == SWD_OFS_CTRL)
    |=> fault && $stable(count))
    else $error("expired counter moved");
  AST_STATUS: assert property (@(posedge pclk) // RL12
    disable iff (!presetn)
    rd_acc && paddr == SWD_OFS_STATUS && pready |->
    prdata[31:2] == 30'h0)
    else $error("status reserved bits nonzero");

  COV_TIMEOUT: cover property (@(posedge pclk) $rose(fault));
  COV_RELOAD:  cover property (@(posedge pclk) reload && enable);
  COV_IRQ:     cover property (@(posedge pclk) $rose(irq));
  COV_ERR:     cover property (@(posedge pclk) pready && pslverr);
endmodule : swd_top

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
module testbench
  import swd_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        halt_main;
  logic        halt_secondary;
  logic        wd_out;
  logic        general_outputs_force_low;
  logic        irq;
  logic [33:0] notes[$];
  logic [33:0] nt;
  logic [31:0] rv;
  logic [31:0] seed;
  logic        sb;
  int          fail_count;
  int          num_checks;

  swd_top dut_u (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .pstrb                     (pstrb),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .halt_main                 (halt_main),
    .halt_secondary            (halt_secondary),
    .wd_out                    (wd_out),
    .general_outputs_force_low (general_outputs_force_low),
    .irq                       (irq)
  );

  always #25 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // note is {expected pslverr, compare data, data}
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [33:0] n);
    int k;
    notes.push_back(n);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      $display("Error at %0t: transfer timeout", $time);
      fail_count++;
      results();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, {2'b00, 32'h0});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {2'b01, e});
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // answer watcher: oldest note against each completed transfer
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      nt = notes.pop_front();
      check(pslverr, nt[33]);
      if (nt[32])
        check(prdata, nt[31:0]);
    end
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    fail_count = 0;
    num_checks = 0;
    seed = 32'd26;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(wd_out, 1'b0);
    rd(SWD_OFS_CTRL, 32'h0);
    rd(SWD_OFS_STATUS, 32'h0);
    rd(SWD_OFS_START, 32'h0000fffe);
    xfer(1'b0, 8'h20, 32'h0, {2'b10, 32'h0});
    $display("test reset done");
    wr(SWD_OFS_RELOAD, 32'h1);
    rd(SWD_OFS_IRQ_ST, 32'h0);
    rd(SWD_OFS_COUNT, 32'h0);
    wr(SWD_OFS_START, 32'h0);
    wr(SWD_OFS_START, 32'hffff);
    rd(SWD_OFS_START, 32'h0000fffe);
    repeat (4)
    begin
      rv = (rnd() % 32'hfffe) + 32'h1;
      wr(SWD_OFS_START, rv);
      rd(SWD_OFS_START, rv);
    end
    $display("test start range done");
    wr(SWD_OFS_START, 32'h2);
    wr(SWD_OFS_STANDBY, 32'h0);
    wr(SWD_OFS_IRQ_MSK, 32'h1);
    wr(SWD_OFS_CTRL, 32'hf1);
    settle();
    check(wd_out, 1'b1);
    check(halt_main, 1'b0);
    rd(SWD_OFS_COUNT, 32'h2);
    repeat (250) @(posedge pclk);
    rd(SWD_OFS_COUNT, 32'h1);
    repeat (200) @(posedge pclk);
    settle();
    check(wd_out, 1'b0);
    check(irq, 1'b1);
    repeat (500) @(posedge pclk);
    rd(SWD_OFS_COUNT, 32'h0);
    rd(SWD_OFS_STATUS, 32'h3);
    rd(SWD_OFS_IRQ_ST, 32'h1);
    wr(SWD_OFS_IRQ_ST, 32'h1);
    settle();
    check(irq, 1'b0);
    wr(SWD_OFS_RELOAD, 32'h1);
    settle();
    check(wd_out, 1'b1);
    check(halt_main, 1'b0);
    rd(SWD_OFS_STATUS, 32'h1);
    rd(SWD_OFS_IRQ_ST, 32'h2);
    // reloads well inside two ticks keep the count off zero
    repeat (3)
    begin
      repeat (150) @(posedge pclk);
      wr(SWD_OFS_RELOAD, 32'h1);
    end
    rd(SWD_OFS_STATUS, 32'h1);
    $display("test expiry and reload done");
    wr(SWD_OFS_IRQ_MSK, 32'h0);
    wr(SWD_OFS_IRQ_ST, 32'h3);
    // stop the running counter so each pass starts from a fresh load
    wr(SWD_OFS_CTRL, 32'h0);
    for (int m = 0; m < 16; m++)
    begin
      rv = rnd();
      sb = rv[0];
      wr(SWD_OFS_STANDBY, {31'h0, sb});
      wr(SWD_OFS_START, 32'h1);
      wr(SWD_OFS_CTRL, (m << 4) | 1);
      repeat (220) @(posedge pclk);
      settle();
      check(halt_main, m[0]);
      check(halt_secondary, m[1]);
      check(wd_out, m[2] ? 1'b0 : sb);
      check(general_outputs_force_low, m[3]);
      check(irq, 1'b0);
      rd(SWD_OFS_STATUS, 32'h3);
      wr(SWD_OFS_CTRL, 32'h0);
      settle();
      check(wd_out, sb);
      rd(SWD_OFS_STATUS, 32'h0);
    end
    $display("test action modes done");
    wr(SWD_OFS_STANDBY, 32'h1);
    settle();
    check(wd_out, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(wd_out, 1'b0);
    rd(SWD_OFS_STANDBY, 32'h0);
    rd(SWD_OFS_CTRL, 32'h0);
    $display("test mid-run reset done");
    results();
  end
endmodule : testbench
